// file: verilog/strap_pkg.sv
// Package: register map, field positions and strap defaults for the soft-strap block
package strap_pkg;
   // Register byte offsets
   localparam logic [7:0] OFF_STRAP_SRC = 8'h00;
   localparam logic [7:0] OFF_P2_BASIC = 8'h04;
   localparam logic [7:0] OFF_P2_ADV = 8'h08;
   localparam logic [7:0] OFF_P2_MODES = 8'h0C;
   localparam logic [7:0] OFF_P2_FC = 8'h10;
   localparam logic [7:0] OFF_HOST_FC = 8'h14;
   localparam logic [7:0] OFF_VPHY_SCS = 8'h18;
   localparam logic [7:0] OFF_STATUS = 8'h1C;
   // Field positions
   localparam int BASIC_DUPLEX_BIT = 8;
   localparam int BASIC_SPEED_BIT = 13;
   localparam int ADV_10HD_BIT = 5;
   localparam int ADV_10FD_BIT = 6;
   localparam int ADV_PAUSE_BIT = 10;
   localparam int MODE_LSB = 5;
   localparam int FC_JAM_BIT = 0;
   localparam int FC_MANUAL_BIT = 1;
   localparam int FC_TX_BIT = 2;
   localparam int FC_RX_BIT = 3;
   localparam int SCS_HEARTBEAT_BIT = 0;
   // Strap source register: software-visible strap values in use, pin levels or loader override
   localparam int SRC_SPEED = 0;
   localparam int SRC_DUPLEX = 1;
   localparam int SRC_P2_JAM = 2;
   localparam int SRC_P2_PAUSE = 3;
   localparam int SRC_P2_MANUAL = 4;
   localparam int SRC_H_JAM = 5;
   localparam int SRC_H_PAUSE = 6;
   localparam int SRC_H_MANUAL = 7;
   localparam int SRC_HEARTBEAT = 8;
   localparam int STRAP_W = 9;
   // Pin defaults when no override is applied (order of SRC_* above)
   localparam logic [8:0] STRAP_DEFAULT = 9'h06F;
   localparam logic [2:0] MODE_10HD = 3'h0;
   localparam logic [2:0] MODE_10FD = 3'h1;
   localparam logic [2:0] MODE_100HD = 3'h2;
   localparam logic [2:0] MODE_100FD = 3'h3;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Packed MSB first, so speed lands on bit 0 as in the pin order
   typedef struct packed {
      logic heartbeat;
      logic h_manual;
      logic h_pause;
      logic h_jam;
      logic p2_manual;
      logic p2_pause;
      logic p2_jam;
      logic duplex;
      logic speed;
   } strap_t;

   typedef struct packed {
      logic jam_enable;
      logic manual_pause_select;
      logic tx_pause_enable;
      logic rx_pause_enable;
   } fc_ctrl_t;
endpackage

// file: verilog/strap_sampler.sv
// Strap pin synchroniser with two-stage agreement filter
`timescale 1ns/1ps
module strap_sampler #(
   parameter int W = 9
) (
   input wire logic aclk, // System clock
   input wire logic aresetn, // Synchronous reset, active low
   input wire logic [W-1:0] pins, // Raw strap pins
   output logic [W-1:0] level // Filtered strap levels
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] level;
   } samp_state_t;

   samp_state_t st_r;
   samp_state_t st_nxt;

   // =====================================
   // Filter
   always_comb begin
      st_nxt = st_r;
      st_nxt.s1 = pins;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      // A change counts only when stages two and three agree
      for (int i = 0; i < W; i++) begin
         if (st_r.s2[i] == st_r.s3[i]) begin
            st_nxt.level[i] = st_r.s3[i];
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign level = st_r.level;
endmodule // strap_sampler

// file: verilog/soft_strap_defaults.sv
// Soft-strap default loader with AXI4-Lite register access
// Operation
// - The port 2 rate strap sets the default of the speed bit, low 10 Mbps, high 100 Mbps, default high.
// - The rate strap also sets the default of the mode field; 10BASE-T half advertisement bit 5 defaults high regardless.
// - The port 2 duplex strap sets the default of the duplex bit, low half, high full, default high.
// - The duplex strap also sets defaults of advertisement bit 6 and the mode field.
// - The port 2 jam strap sets the default of the backpressure enable, default high.
// - The port 2 pause strap sets defaults of both transmit and receive pause enables.
// - A low port 2 manual strap keeps negotiated flow control and sets advertisement bit 10.
// - A high port 2 manual strap uses the enable bits and clears advertisement bit 10.
// - The host port jam strap sets that port's backpressure enable default, default high.
// - The host port pause strap sets defaults of that port's transmit and receive pause enables.
// - The host port manual strap chooses between virtual negotiation result and the enable bits.
// - The heartbeat strap sets the default of heartbeat-off bit 0, high disables the test.
// - Soft-strap values may be overridden by the configuration loader before use as defaults.
`timescale 1ns/1ps
module soft_strap_defaults (
   input wire logic aclk, // System clock
   input wire logic aresetn, // Synchronous reset, active low
   input wire logic [strap_pkg::STRAP_W-1:0] strap_pins, // Soft strap pins
   input wire logic loader_valid, // Loader override strobe
   input wire logic [strap_pkg::STRAP_W-1:0] loader_straps, // Loader override values
   input wire logic loader_done, // Loader finished, defaults may be applied
   input wire logic p2_neg_tx_pause, // Negotiated transmit pause, port 2
   input wire logic p2_neg_rx_pause, // Negotiated receive pause, port 2
   input wire logic h_neg_tx_pause, // Virtual negotiated transmit pause, host port
   input wire logic h_neg_rx_pause, // Virtual negotiated receive pause, host port
   output logic p2_tx_pause_active, // Effective transmit pause, port 2
   output logic p2_rx_pause_active, // Effective receive pause, port 2
   output logic h_tx_pause_active, // Effective transmit pause, host port
   output logic h_rx_pause_active, // Effective receive pause, host port
   output logic p2_jam_active, // Port 2 backpressure enable
   output logic h_jam_active, // Host port backpressure enable
   output logic heartbeat_off, // Heartbeat test disabled
   output logic defaults_loaded, // Defaults applied
   input wire logic [7:0] s_axi_awaddr, // Write address
   input wire logic s_axi_awvalid, // Write address valid
   output logic s_axi_awready, // Write address ready
   input wire logic [31:0] s_axi_wdata, // Write data
   input wire logic [3:0] s_axi_wstrb, // Write strobes
   input wire logic s_axi_wvalid, // Write data valid
   output logic s_axi_wready, // Write data ready
   output logic [1:0] s_axi_bresp, // Write response
   output logic s_axi_bvalid, // Write response valid
   input wire logic s_axi_bready, // Write response ready
   input wire logic [7:0] s_axi_araddr, // Read address
   input wire logic s_axi_arvalid, // Read address valid
   output logic s_axi_arready, // Read address ready
   output logic [31:0] s_axi_rdata, // Read data
   output logic [1:0] s_axi_rresp, // Read response
   output logic s_axi_rvalid, // Read valid
   input wire logic s_axi_rready // Read ready
);
   typedef struct packed {
      strap_pkg::strap_t src;
      logic overridden;
      logic loaded;
      logic speed;
      logic duplex;
      logic [15:0] adv;
      logic [2:0] mode;
      strap_pkg::fc_ctrl_t p2_fc;
      strap_pkg::fc_ctrl_t h_fc;
      logic heartbeat;
      logic aw_held;
      logic [7:0] aw_addr;
      logic w_held;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } state_t;

   state_t st_r;
   state_t st_nxt;
   logic [strap_pkg::STRAP_W-1:0] pin_level;

   strap_sampler #(.W(strap_pkg::STRAP_W)) u_sampler (
      .aclk(aclk),
      .aresetn(aresetn),
      .pins(strap_pins),
      .level(pin_level)
   );

   // =====================================
   // Helpers
   function automatic logic [2:0] mode_of(input logic spd, input logic dup);
      logic [2:0] m;
      m = spd ? (dup ? strap_pkg::MODE_100FD : strap_pkg::MODE_100HD)
              : (dup ? strap_pkg::MODE_10FD : strap_pkg::MODE_10HD);
      return m;
   endfunction

   function automatic logic [31:0] fc_word(input strap_pkg::fc_ctrl_t f);
      logic [31:0] v;
      v = 32'h0000_0000;
      v[strap_pkg::FC_JAM_BIT] = f.jam_enable;
      v[strap_pkg::FC_MANUAL_BIT] = f.manual_pause_select;
      v[strap_pkg::FC_TX_BIT] = f.tx_pause_enable;
      v[strap_pkg::FC_RX_BIT] = f.rx_pause_enable;
      return v;
   endfunction

   function automatic strap_pkg::fc_ctrl_t fc_merge(input strap_pkg::fc_ctrl_t f, input logic [31:0] d,
                                                   input logic [3:0] be);
      strap_pkg::fc_ctrl_t o;
      o = f;
      if (be[0]) begin
         o.jam_enable = d[strap_pkg::FC_JAM_BIT];
         o.manual_pause_select = d[strap_pkg::FC_MANUAL_BIT];
         o.tx_pause_enable = d[strap_pkg::FC_TX_BIT];
         o.rx_pause_enable = d[strap_pkg::FC_RX_BIT];
      end
      return o;
   endfunction

   // =====================================
   // Next state
   logic do_write;
   logic do_read;
   logic aw_take;
   logic w_take;
   logic ar_take;
   logic [31:0] rd_word;
   logic rd_ok;
   logic wr_ok;

   always_comb begin
      st_nxt = st_r;
      aw_take = s_axi_awvalid && !st_r.aw_held && !st_r.bvalid;
      w_take = s_axi_wvalid && !st_r.w_held && !st_r.bvalid;
      ar_take = s_axi_arvalid && !st_r.rvalid;
      do_write = 1'b0;
      do_read = ar_take;
      wr_ok = 1'b0;
      rd_ok = 1'b1;
      rd_word = 32'h0000_0000;

      // Loader overrides win over pin levels until defaults are applied
      if (!st_r.loaded) begin
         if (loader_valid) begin
            st_nxt.src = strap_pkg::strap_t'(loader_straps);
            st_nxt.overridden = 1'b1;
         end else if (!st_r.overridden) begin
            st_nxt.src = strap_pkg::strap_t'(pin_level);
         end
      end

      // Apply defaults once the loader has finished
      if (!st_r.loaded && loader_done) begin
         st_nxt.loaded = 1'b1;
         st_nxt.speed = st_nxt.src.speed;
         st_nxt.duplex = st_nxt.src.duplex;
         st_nxt.adv[strap_pkg::ADV_10HD_BIT] = 1'b1;
         st_nxt.adv[strap_pkg::ADV_10FD_BIT] = st_nxt.src.duplex;
         st_nxt.adv[strap_pkg::ADV_PAUSE_BIT] = !st_nxt.src.p2_manual;
         st_nxt.mode = mode_of(st_nxt.src.speed, st_nxt.src.duplex);
         st_nxt.p2_fc.jam_enable = st_nxt.src.p2_jam;
         st_nxt.p2_fc.tx_pause_enable = st_nxt.src.p2_pause;
         st_nxt.p2_fc.rx_pause_enable = st_nxt.src.p2_pause;
         st_nxt.p2_fc.manual_pause_select = st_nxt.src.p2_manual;
         st_nxt.h_fc.jam_enable = st_nxt.src.h_jam;
         st_nxt.h_fc.tx_pause_enable = st_nxt.src.h_pause;
         st_nxt.h_fc.rx_pause_enable = st_nxt.src.h_pause;
         st_nxt.h_fc.manual_pause_select = st_nxt.src.h_manual;
         st_nxt.heartbeat = st_nxt.src.heartbeat;
      end

      // Write channel capture
      if (aw_take) begin
         st_nxt.aw_held = 1'b1;
         st_nxt.aw_addr = s_axi_awaddr;
      end
      if (w_take) begin
         st_nxt.w_held = 1'b1;
         st_nxt.w_data = s_axi_wdata;
         st_nxt.w_strb = s_axi_wstrb;
      end
      do_write = st_r.aw_held && st_r.w_held && !st_r.bvalid;

      // Software writes are not held off until defaults are in; the load overwrites one taken before it, except advertisement bits other than 5, 6 and 10
      if (do_write) begin
         wr_ok = 1'b1;
         unique case (st_r.aw_addr)
            strap_pkg::OFF_P2_BASIC: begin
               if (st_r.w_strb[1]) begin
                  st_nxt.speed = st_r.w_data[strap_pkg::BASIC_SPEED_BIT];
                  st_nxt.duplex = st_r.w_data[strap_pkg::BASIC_DUPLEX_BIT];
               end
            end
            strap_pkg::OFF_P2_ADV: begin
               if (st_r.w_strb[0]) begin
                  st_nxt.adv[7:0] = st_r.w_data[7:0];
               end
               if (st_r.w_strb[1]) begin
                  st_nxt.adv[15:8] = st_r.w_data[15:8];
               end
            end
            strap_pkg::OFF_P2_MODES: begin
               if (st_r.w_strb[0]) begin
                  st_nxt.mode = st_r.w_data[strap_pkg::MODE_LSB +: 3];
               end
            end
            strap_pkg::OFF_P2_FC: st_nxt.p2_fc = fc_merge(st_r.p2_fc, st_r.w_data, st_r.w_strb);
            strap_pkg::OFF_HOST_FC: st_nxt.h_fc = fc_merge(st_r.h_fc, st_r.w_data, st_r.w_strb);
            strap_pkg::OFF_VPHY_SCS: begin
               if (st_r.w_strb[0]) begin
                  st_nxt.heartbeat = st_r.w_data[strap_pkg::SCS_HEARTBEAT_BIT];
               end
            end
            strap_pkg::OFF_STRAP_SRC, strap_pkg::OFF_STATUS: wr_ok = 1'b1;
            default: wr_ok = 1'b0;
         endcase
         st_nxt.aw_held = 1'b0;
         st_nxt.w_held = 1'b0;
         st_nxt.bvalid = 1'b1;
         st_nxt.bresp = wr_ok ? strap_pkg::RESP_OKAY : strap_pkg::RESP_SLVERR;
      end
      if (st_r.bvalid && s_axi_bready) begin
         st_nxt.bvalid = 1'b0;
      end

      // Read decode
      unique case (s_axi_araddr)
         strap_pkg::OFF_STRAP_SRC: rd_word = {23'h000000, st_r.src};
         strap_pkg::OFF_P2_BASIC: begin
            rd_word[strap_pkg::BASIC_SPEED_BIT] = st_r.speed;
            rd_word[strap_pkg::BASIC_DUPLEX_BIT] = st_r.duplex;
         end
         strap_pkg::OFF_P2_ADV: rd_word = {16'h0000, st_r.adv};
         strap_pkg::OFF_P2_MODES: rd_word[strap_pkg::MODE_LSB +: 3] = st_r.mode;
         strap_pkg::OFF_P2_FC: rd_word = fc_word(st_r.p2_fc);
         strap_pkg::OFF_HOST_FC: rd_word = fc_word(st_r.h_fc);
         strap_pkg::OFF_VPHY_SCS: rd_word[strap_pkg::SCS_HEARTBEAT_BIT] = st_r.heartbeat;
         strap_pkg::OFF_STATUS: rd_word = {30'h00000000, st_r.overridden, st_r.loaded};
         default: rd_ok = 1'b0;
      endcase
      if (do_read) begin
         st_nxt.rvalid = 1'b1;
         st_nxt.rdata = rd_word;
         st_nxt.rresp = rd_ok ? strap_pkg::RESP_OKAY : strap_pkg::RESP_SLVERR;
      end else if (st_r.rvalid && s_axi_rready) begin
         st_nxt.rvalid = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_r <= '0;
         st_r.src <= strap_pkg::strap_t'(strap_pkg::STRAP_DEFAULT);
      end else begin
         st_r <= st_nxt;
      end
   end

   // =====================================
   // Outputs
   // Manual select picks the enable bits, otherwise the negotiated result
   assign p2_tx_pause_active = st_r.p2_fc.manual_pause_select ? st_r.p2_fc.tx_pause_enable
                                                               : p2_neg_tx_pause;
   assign p2_rx_pause_active = st_r.p2_fc.manual_pause_select ? st_r.p2_fc.rx_pause_enable
                                                               : p2_neg_rx_pause;
   assign h_tx_pause_active = st_r.h_fc.manual_pause_select ? st_r.h_fc.tx_pause_enable
                                                             : h_neg_tx_pause;
   assign h_rx_pause_active = st_r.h_fc.manual_pause_select ? st_r.h_fc.rx_pause_enable
                                                             : h_neg_rx_pause;
   assign p2_jam_active = st_r.p2_fc.jam_enable;
   assign h_jam_active = st_r.h_fc.jam_enable;
   assign heartbeat_off = st_r.heartbeat;
   assign defaults_loaded = st_r.loaded;
   assign s_axi_awready = !st_r.aw_held && !st_r.bvalid;
   assign s_axi_wready = !st_r.w_held && !st_r.bvalid;
   assign s_axi_bvalid = st_r.bvalid;
   assign s_axi_bresp = st_r.bresp;
   assign s_axi_arready = !st_r.rvalid;
   assign s_axi_rvalid = st_r.rvalid;
   assign s_axi_rdata = st_r.rdata;
   assign s_axi_rresp = st_r.rresp;
endmodule // soft_strap_defaults

// file: sim/strap_partner.sv
// Partner model: strap resistors and the configuration loader
`timescale 1ns/1ps
module strap_partner (
   input wire logic aclk, // Clock
   input wire logic aresetn, // Reset, active low
   input wire logic [8:0] pin_cfg, // Resistor levels
   input wire logic [8:0] ovr_cfg, // Loader image
   input wire logic use_ovr, // Loader supplies straps
   input wire logic late_ovr, // Stray strobe after load
   output logic [8:0] strap_pins, // To block
   output logic loader_valid, // Override strobe
   output logic [8:0] loader_straps, // Override values
   output logic loader_done // Loader finished
);
   logic [4:0] cnt_r;
   always_ff @(posedge aclk) begin
      if (!aresetn) cnt_r <= 5'h00;
      else if (cnt_r != 5'h1F) cnt_r <= cnt_r + 5'h01;
   end
   // Resistors are static; the loader waits long enough for the pin filter to settle
   assign strap_pins = pin_cfg;
   assign loader_done = (cnt_r >= 5'h08);
   // The stray strobe stands as a level once the counter has parked, so it always lands after the load
   assign loader_valid = (use_ovr && cnt_r == 5'h08) || (late_ovr && cnt_r == 5'h1F);
   // Outside its strobe the image bus carries a count-derived pattern, which holds at 9'h1FF once the counter parks
   assign loader_straps = (use_ovr && cnt_r == 5'h08) ? ovr_cfg : {cnt_r[3:0], cnt_r};
endmodule // strap_partner

// file: sim/strap_checker_sva.sv
// Concurrent checks on the ports of the soft-strap loader
`timescale 1ns/1ps
module strap_checker (
   input wire logic aclk, // Clock
   input wire logic aresetn, // Reset, active low
   input wire logic loader_valid, // Override strobe
   input wire logic [8:0] loader_straps, // Override values
   input wire logic loader_done, // Loader finished
   input wire logic p2_neg_tx_pause, // Negotiated tx, port 2
   input wire logic h_neg_tx_pause, // Negotiated tx, host
   input wire logic p2_tx_pause_active, // Effective tx, port 2
   input wire logic h_tx_pause_active, // Effective tx, host
   input wire logic p2_jam_active, // Port 2 jam
   input wire logic h_jam_active, // Host jam
   input wire logic heartbeat_off, // Heartbeat off
   input wire logic defaults_loaded, // Loaded flag
   input wire logic s_axi_awvalid, // AW valid
   input wire logic s_axi_awready, // AW ready
   input wire logic s_axi_wvalid, // W valid
   input wire logic s_axi_wready, // W ready
   input wire logic [1:0] s_axi_bresp, // B resp
   input wire logic s_axi_bvalid, // B valid
   input wire logic s_axi_bready, // B ready
   input wire logic s_axi_arvalid, // AR valid
   input wire logic s_axi_arready, // AR ready
   input wire logic [31:0] s_axi_rdata, // R data
   input wire logic s_axi_rvalid, // R valid
   input wire logic s_axi_rready // R ready
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence load_ovr;
      loader_valid && loader_done && !defaults_loaded;
   endsequence
   a_load_next: assert property (loader_done && !defaults_loaded |=> defaults_loaded)
      else $error("defaults not loaded one cycle after loader done");
   a_loaded_sticky: assert property (defaults_loaded |=> defaults_loaded)
      else $error("loaded flag dropped");
   a_override_used: assert property (load_ovr |=> p2_jam_active == $past(loader_straps[2])
      && h_jam_active == $past(loader_straps[5]) && heartbeat_off == $past(loader_straps[8]))
      else $error("override value not applied");
   a_p2_pause_sel: assert property (load_ovr |=> p2_tx_pause_active ==
      ($past(loader_straps[4]) ? $past(loader_straps[3]) : p2_neg_tx_pause))
      else $error("port 2 pause select wrong");
   a_host_pause_sel: assert property (load_ovr |=> h_tx_pause_active ==
      ($past(loader_straps[7]) ? $past(loader_straps[6]) : h_neg_tx_pause))
      else $error("host pause select wrong");
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:3] s_axi_bvalid)
      else $error("write response late");
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response not held");
   a_ready_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write ready while response pending");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data not held");
   c_override: cover property (load_ovr);
   c_slverr: cover property (s_axi_bvalid && s_axi_bresp == strap_pkg::RESP_SLVERR);
   c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule // strap_checker

bind soft_strap_defaults strap_checker i_chk (.*);

// file: sim/soft_strap_defaults_bench.sv
// Self-checking bench for the soft-strap default loader
`timescale 1ns/1ps
module soft_strap_defaults_bench;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [8:0] pin_cfg = 9'h06F, ovr_cfg = 9'h000;
   logic use_ovr = 1'b0, late_ovr = 1'b0;
   logic p2_neg_tx_pause = 1'b0, p2_neg_rx_pause = 1'b0, h_neg_tx_pause = 1'b0, h_neg_rx_pause = 1'b0;
   logic [8:0] strap_pins, loader_straps;
   logic loader_valid, loader_done, defaults_loaded, p2_jam_active, h_jam_active, heartbeat_off;
   logic p2_tx_pause_active, p2_rx_pause_active, h_tx_pause_active, h_rx_pause_active;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   int bad_count = 0;
   int n_tests = 0;
   always #2 aclk = ~aclk;
   strap_partner i_far (.aclk, .aresetn, .pin_cfg, .ovr_cfg, .use_ovr, .late_ovr, .strap_pins,
      .loader_valid, .loader_straps, .loader_done);
   soft_strap_defaults i_dut (.aclk, .aresetn, .strap_pins, .loader_valid, .loader_straps, .loader_done,
      .p2_neg_tx_pause, .p2_neg_rx_pause, .h_neg_tx_pause, .h_neg_rx_pause, .p2_tx_pause_active,
      .p2_rx_pause_active, .h_tx_pause_active, .h_rx_pause_active, .p2_jam_active, .h_jam_active,
      .heartbeat_off, .defaults_loaded, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   // ==========
   // Reporting
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic give_up();
      bad_count++;
      conclude();
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         bad_count++;
      end
   endtask
   // ==========
   // Bus cycles; ready is looked at mid-cycle and acted on at the next rising edge
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] e);
      logic aw_hit, w_hit, b_hit;
      logic [1:0] resp;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (int n = 0; n < 40; n++) begin
         @(negedge aclk);
         aw_hit = s_axi_awvalid && s_axi_awready;
         w_hit = s_axi_wvalid && s_axi_wready;
         b_hit = s_axi_bvalid;
         resp = s_axi_bresp;
         @(posedge aclk);
         if (aw_hit) s_axi_awvalid <= 1'b0;
         if (w_hit) s_axi_wvalid <= 1'b0;
         if (b_hit) begin
            s_axi_bready <= 1'b0;
            check(resp, e);
            return;
         end
      end
      give_up();
   endtask
   task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ar_hit, r_hit;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (int n = 0; n < 40; n++) begin
         @(negedge aclk);
         ar_hit = s_axi_arvalid && s_axi_arready;
         r_hit = s_axi_rvalid;
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge aclk);
         if (ar_hit) s_axi_arvalid <= 1'b0;
         if (r_hit) begin
            s_axi_rready <= 1'b0;
            return;
         end
      end
      give_up();
   endtask
   // Reset with new strap sources, then wait for the load
   task automatic restart(input logic [8:0] pins, input logic [8:0] ovr, input logic use_it);
      @(posedge aclk);
      aresetn <= 1'b0;
      pin_cfg <= pins;
      ovr_cfg <= ovr;
      use_ovr <= use_it;
      late_ovr <= 1'b0;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      for (int n = 0; n < 40 && defaults_loaded !== 1'b1; n++) @(negedge aclk);
      if (defaults_loaded !== 1'b1) give_up();
      @(posedge aclk);
   endtask
   // Every register and output against the strap vector p
   task automatic check_all(input logic [8:0] p, input logic ovr);
      logic [31:0] exp [8];
      logic [31:0] d;
      logic [1:0] r;
      exp[0] = {23'h000000, p};
      exp[1] = {18'h00000, p[0], 4'h0, p[1], 8'h00};
      exp[2] = {21'h000000, ~p[4], 3'h0, p[1], 1'b1, 5'h00};
      exp[3] = {24'h000000, 1'b0, p[0], p[1], 5'h00};
      exp[4] = {28'h0000000, p[3], p[3], p[4], p[2]};
      exp[5] = {28'h0000000, p[6], p[6], p[7], p[5]};
      exp[6] = {31'h00000000, p[8]};
      exp[7] = {30'h00000000, ovr, 1'b1};
      for (int i = 0; i < 8; i++) begin
         axi_read(8'(4 * i), d, r);
         check(d, exp[i]);
         check(r, strap_pkg::RESP_OKAY);
      end
      check({p2_jam_active, h_jam_active, heartbeat_off}, {p[2], p[5], p[8]});
      check({p2_tx_pause_active, p2_rx_pause_active}, p[4] ? {2{p[3]}} : {p2_neg_tx_pause, p2_neg_rx_pause});
      check({h_tx_pause_active, h_rx_pause_active}, p[7] ? {2{p[6]}} : {h_neg_tx_pause, h_neg_rx_pause});
   endtask
   // ==========
   // Scenarios
   task automatic t_pin_defaults();
      logic [8:0] v [5] = '{9'h06F, 9'h0B6, 9'h149, 9'h000, 9'h1FF};
      p2_neg_tx_pause <= 1'b1;
      h_neg_rx_pause <= 1'b1;
      foreach (v[i]) begin
         restart(v[i], 9'h000, 1'b0);
         check_all(v[i], 1'b0);
      end
   endtask
   task automatic t_override();
      restart(9'h0B6, 9'h149, 1'b1);
      check_all(9'h149, 1'b1);
      late_ovr <= 1'b1;
      repeat (16) @(posedge aclk);
      check_all(9'h149, 1'b1);
   endtask
   task automatic t_software();
      logic [31:0] d;
      logic [1:0] r;
      restart(9'h0B6, 9'h000, 1'b0);
      axi_write(strap_pkg::OFF_P2_FC, 32'h0000_0006, 4'h2, strap_pkg::RESP_OKAY);
      axi_read(strap_pkg::OFF_P2_FC, d, r);
      check(d, 32'h0000_0003);
      axi_write(strap_pkg::OFF_P2_FC, 32'h0000_0006, 4'h1, strap_pkg::RESP_OKAY);
      check({p2_tx_pause_active, p2_rx_pause_active, p2_jam_active}, 3'h4);
      axi_write(strap_pkg::OFF_HOST_FC, 32'h0000_0000, 4'h1, strap_pkg::RESP_OKAY);
      h_neg_tx_pause <= 1'b1;
      h_neg_rx_pause <= 1'b0;
      @(posedge aclk);
      check({h_tx_pause_active, h_rx_pause_active, h_jam_active}, 3'h4);
      axi_write(strap_pkg::OFF_VPHY_SCS, 32'h0000_0001, 4'h1, strap_pkg::RESP_OKAY);
      check(heartbeat_off, 1'b1);
      axi_write(8'h20, 32'h0000_0001, 4'hF, strap_pkg::RESP_SLVERR);
      axi_read(8'h20, d, r);
      check(d, 32'h0000_0000);
      check(r, strap_pkg::RESP_SLVERR);
      axi_write(strap_pkg::OFF_STRAP_SRC, 32'h0000_01FF, 4'hF, strap_pkg::RESP_OKAY);
      axi_read(strap_pkg::OFF_STRAP_SRC, d, r);
      check(d, 32'h0000_00B6);
   endtask
   initial begin
      t_pin_defaults();
      t_override();
      t_software();
      conclude();
   end
endmodule // soft_strap_defaults_bench
